// *** include/dsb_pkg.sv ***
package dsb_pkg;

  localparam int DATA_W       = 36;
  localparam int ADDR_W       = 20;
  localparam int LANES        = 4;
  localparam int LANE_W       = 9;
  localparam int BURST_LEN    = 2;
  localparam int FIFO_DEPTH   = 32;
  localparam int FIFO_CNT_W   = 6;
  localparam int FIFO_RESERVE = 3;

  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_BURSTS = 4'h8;

  localparam int CTRL_ORG_LSB     = 0;
  localparam int CTRL_EN_BIT      = 2;
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_CNT_LSB   = 3;
  localparam int STATUS_READY_BIT = 9;

  localparam logic       CTRL_EN_RST  = 1'b1;
  localparam logic [3:0] LANES_NONE   = 4'hf;

  typedef enum logic [1:0] {
    ORG_X36 = 2'b00,
    ORG_X18 = 2'b01,
    ORG_X9  = 2'b10
  } dsb_org_e;

  localparam dsb_org_e CTRL_ORG_RST = ORG_X36;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WR0  = 3'b001,
    ST_WR1  = 3'b010,
    ST_RD0  = 3'b011,
    ST_RD1  = 3'b100
  } dsb_state_e;

  typedef struct packed {
    logic              load_n;
    logic              read_write;
    logic [ADDR_W-1:0] addr;
  } dsb_cmd_s;

  typedef struct packed {
    logic lane3_write_n;
    logic lane2_write_n;
    logic lane1_write_n;
    logic lane0_write_n;
    logic single_lane_write_n;
  } dsb_lanes_s;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } dsb_av_req_s;

  typedef struct packed {
    dsb_state_e        state;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic              dq_oe;
    dsb_org_e          org;
    logic              en;
    logic              ack;
    logic [31:0]       rdata;
    logic [15:0]       bursts;
    logic              echo;
  } dsb_top_s;

endpackage : dsb_pkg

// *** verilog/dsb_fifo.sv ***
`timescale 1ns/1ps
module dsb_fifo #(
  parameter int W     = dsb_pkg::DATA_W,
  parameter int DEPTH = dsb_pkg::FIFO_DEPTH
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [W-1:0]           in_data,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [W-1:0]                out_data,
  output logic [$clog2(DEPTH):0]      count
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0]   cnt;
  } dsb_fifo_st_s;

  dsb_fifo_st_s fifo_reg;
  dsb_fifo_st_s fifo_next;
  logic [W-1:0] mem [DEPTH];
  logic         push;
  logic         pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign in_ready  = fifo_reg.cnt != (AW+1)'(DEPTH);
  assign out_valid = fifo_reg.cnt != '0;
  assign out_data  = mem[fifo_reg.rptr];
  assign count     = fifo_reg.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    fifo_next = fifo_reg;
    if (push) begin
      fifo_next.wptr = bump(fifo_reg.wptr);
    end
    if (pop) begin
      fifo_next.rptr = bump(fifo_reg.rptr);
    end
    case ({push, pop})
      2'b10:   fifo_next.cnt = fifo_reg.cnt + 1'b1;
      2'b01:   fifo_next.cnt = fifo_reg.cnt - 1'b1;
      default: fifo_next.cnt = fifo_reg.cnt;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fifo_reg <= '0;
    end else if (ce) begin
      fifo_reg <= fifo_next;
    end
  end

  // Storage needs no reset; only words below the count are ever read
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[fifo_reg.wptr] <= in_data;
    end
  end

endmodule : dsb_fifo

// *** verilog/dsb_sram.sv ***
`timescale 1ns/1ps
// Behaviour
// - x36: four lane selects gate 9-bit groups
// - x36: all selects low store all bits
// - selects sampled per beat, only in writes
// - x18: two lane selects gate groups
// - x18: both selects low store 18 bits
// - x9: single select, may differ per beat
// - second beat address flips low bit internally
// - every bus cycle ends after two beats
// - state advances on true clock edges only
// - linear order: 0 then 1, 1 then 0
// - load low, direction low starts write
// - load low, direction high starts read
module dsb_sram (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              ce,
  input  wire dsb_pkg::dsb_cmd_s                 cmd,
  input  wire dsb_pkg::dsb_lanes_s               lanes,
  input  wire logic [dsb_pkg::DATA_W-1:0]        dq_i,
  output logic [dsb_pkg::DATA_W-1:0]             dq_o,
  output logic                                   dq_oe,
  output logic                                   echo_clock,
  output logic                                   cmd_ready,
  output logic [dsb_pkg::DATA_W-1:0]             rd_data,
  output logic                                   rd_valid,
  input  wire logic                              rd_ready,
  input  wire dsb_pkg::dsb_av_req_s              av_req,
  output logic [31:0]                            avs_readdata,
  output logic                                   avs_waitrequest
);

  dsb_pkg::dsb_top_s                   top_reg;
  dsb_pkg::dsb_top_s                   top_next;
  logic [dsb_pkg::DATA_W-1:0]          mem [2**dsb_pkg::ADDR_W];
  logic [dsb_pkg::FIFO_CNT_W-1:0]      fifo_cnt;
  logic                                fifo_in_ready;
  logic                                wr_beat;
  logic [dsb_pkg::ADDR_W-1:0]          wr_addr;
  logic [3:0]                          wr_lanes;
  logic [dsb_pkg::DATA_W-1:0]          wr_word;
  logic                                start_ok;
  logic                                cycle_end;

  // Active-low lane vector for the current organisation; unused lanes read as off
  function automatic logic [3:0] eff_lanes(input dsb_pkg::dsb_org_e org, input dsb_pkg::dsb_lanes_s l);
    case (org)
      dsb_pkg::ORG_X18: eff_lanes = {2'b11, l.lane1_write_n, l.lane0_write_n};
      dsb_pkg::ORG_X9:  eff_lanes = {3'b111, l.single_lane_write_n};
      default:          eff_lanes = {l.lane3_write_n, l.lane2_write_n,
                                     l.lane1_write_n, l.lane0_write_n};
    endcase
  endfunction : eff_lanes

  // Each 9-bit group comes from the new word only when its select is low
  function automatic logic [dsb_pkg::DATA_W-1:0] merge(input logic [dsb_pkg::DATA_W-1:0] old_w,
                                                       input logic [dsb_pkg::DATA_W-1:0] new_w,
                                                       input logic [3:0] sel_n);
    logic [dsb_pkg::DATA_W-1:0] m;
    m = old_w;
    for (int i = 0; i < dsb_pkg::LANES; i++) begin
      if (!sel_n[i]) begin
        m[i*dsb_pkg::LANE_W +: dsb_pkg::LANE_W] = new_w[i*dsb_pkg::LANE_W +: dsb_pkg::LANE_W];
      end
    end
    return m;
  endfunction : merge

  // Linear order on the lowest address bit
  function automatic logic [dsb_pkg::ADDR_W-1:0] burst_next(input logic [dsb_pkg::ADDR_W-1:0] a);
    return {a[dsb_pkg::ADDR_W-1:1], ~a[0]};
  endfunction : burst_next

  function automatic logic [31:0] reg_read(input logic [3:0] a, input dsb_pkg::dsb_top_s s,
                                           input logic [dsb_pkg::FIFO_CNT_W-1:0] cnt, input logic rdy);
    logic [31:0] v;
    v = '0;
    case (a)
      dsb_pkg::REG_CTRL: begin
        v[dsb_pkg::CTRL_ORG_LSB +: 2] = s.org;
        v[dsb_pkg::CTRL_EN_BIT]       = s.en;
      end
      dsb_pkg::REG_STATUS: begin
        v[dsb_pkg::STATUS_STATE_LSB +: 3]                = s.state;
        v[dsb_pkg::STATUS_CNT_LSB +: dsb_pkg::FIFO_CNT_W] = cnt;
        v[dsb_pkg::STATUS_READY_BIT]                     = rdy;
      end
      dsb_pkg::REG_BURSTS: v[15:0] = s.bursts;
      default:             v = '0;
    endcase
    return v;
  endfunction : reg_read

  // Beat 0 samples at the command's address, beat 1 at the advanced one
  assign wr_beat  = (top_reg.state == dsb_pkg::ST_WR0) || (top_reg.state == dsb_pkg::ST_WR1);
  assign wr_addr  = (top_reg.state == dsb_pkg::ST_WR1) ? burst_next(top_reg.addr) : top_reg.addr;
  assign wr_lanes = eff_lanes(top_reg.org, lanes);
  assign wr_word  = merge(mem[wr_addr], dq_i, wr_lanes);

  // Three free slots cover the beat in flight plus both beats of a new read
  assign cmd_ready = fifo_cnt <= dsb_pkg::FIFO_CNT_W'(dsb_pkg::FIFO_DEPTH - dsb_pkg::FIFO_RESERVE);
  assign cycle_end = (top_reg.state == dsb_pkg::ST_IDLE) || (top_reg.state == dsb_pkg::ST_WR1) ||
                     (top_reg.state == dsb_pkg::ST_RD1);
  assign start_ok  = !cmd.load_n && top_reg.en && cycle_end && (!cmd.read_write || cmd_ready);

  assign dq_o            = top_reg.dq_o;
  assign dq_oe           = top_reg.dq_oe;
  assign echo_clock      = top_reg.echo;
  assign avs_readdata    = top_reg.rdata;
  assign avs_waitrequest = (av_req.read || av_req.write) && !top_reg.ack;

  // Forward the word being written this edge so a read straight after a write sees it
  function automatic logic [dsb_pkg::DATA_W-1:0] fetch(input logic [dsb_pkg::ADDR_W-1:0] a,
                                                       input logic hit_ok,
                                                       input logic [dsb_pkg::ADDR_W-1:0] wa,
                                                       input logic [dsb_pkg::DATA_W-1:0] ww,
                                                       input logic [dsb_pkg::DATA_W-1:0] stored);
    return (hit_ok && a == wa) ? ww : stored;
  endfunction : fetch

  always_comb begin
    top_next       = top_reg;
    top_next.echo  = ~top_reg.echo;
    top_next.dq_oe = 1'b0;
    top_next.ack   = 1'b0;

    // Register slave: one wait state, write lands on the edge where waitrequest is seen low
    if ((av_req.read || av_req.write) && !top_reg.ack) begin
      top_next.ack   = 1'b1;
      top_next.rdata = reg_read(av_req.address, top_reg, fifo_cnt, cmd_ready);
    end
    if (top_reg.ack && av_req.write && av_req.address == dsb_pkg::REG_CTRL) begin
      top_next.org = dsb_pkg::dsb_org_e'(av_req.writedata[dsb_pkg::CTRL_ORG_LSB +: 2]);
      top_next.en  = av_req.writedata[dsb_pkg::CTRL_EN_BIT];
    end

    if (top_reg.state == dsb_pkg::ST_WR1 || top_reg.state == dsb_pkg::ST_RD1) begin
      top_next.bursts = top_reg.bursts + 16'h0001;
    end

    case (top_reg.state)
      dsb_pkg::ST_IDLE, dsb_pkg::ST_WR1, dsb_pkg::ST_RD1: begin
        if (start_ok) begin
          top_next.addr = cmd.addr;
          if (cmd.read_write) begin
            top_next.state = dsb_pkg::ST_RD0;
            top_next.dq_o  = fetch(cmd.addr, wr_beat && wr_lanes != dsb_pkg::LANES_NONE,
                                   wr_addr, wr_word, mem[cmd.addr]);
            top_next.dq_oe = 1'b1;
          end else begin
            top_next.state = dsb_pkg::ST_WR0;
          end
        end else begin
          top_next.state = dsb_pkg::ST_IDLE;
        end
      end
      dsb_pkg::ST_WR0: begin
        top_next.state = dsb_pkg::ST_WR1;
      end
      dsb_pkg::ST_RD0: begin
        top_next.state = dsb_pkg::ST_RD1;
        top_next.dq_o  = mem[burst_next(top_reg.addr)];
        top_next.dq_oe = 1'b1;
      end
      default: begin
        top_next.state = dsb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      top_reg       <= '0;
      top_reg.state <= dsb_pkg::ST_IDLE;
      top_reg.org   <= dsb_pkg::CTRL_ORG_RST;
      top_reg.en    <= dsb_pkg::CTRL_EN_RST;
    end else if (ce) begin
      top_reg <= top_next;
    end
  end

  // A beat with every select high skips the array; the burst still runs its two beats
  always_ff @(posedge clk) begin
    if (ce && !rst && wr_beat && wr_lanes != dsb_pkg::LANES_NONE) begin
      mem[wr_addr] <= wr_word;
    end
  end

  // Read beats are queued; new reads wait on cmd_ready when the queue backs up
  dsb_fifo #(
    .W     (dsb_pkg::DATA_W),
    .DEPTH (dsb_pkg::FIFO_DEPTH)
  ) u_rd_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (top_reg.dq_oe),
    .in_ready  (fifo_in_ready),
    .in_data   (top_reg.dq_o),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data),
    .count     (fifo_cnt)
  );

  // Reservation in cmd_ready keeps the queue from overflowing
  logic unused_in_ready;
  assign unused_in_ready = fifo_in_ready;

endmodule : dsb_sram

// *** tb/dsb_sram_monitor.sv ***
`timescale 1ns/1ps
module dsb_sram_monitor (
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic                          ce,
  input wire dsb_pkg::dsb_cmd_s             cmd,
  input wire logic [dsb_pkg::DATA_W-1:0]    dq_o,
  input wire logic                          dq_oe,
  input wire logic                          echo_clock,
  input wire logic [dsb_pkg::DATA_W-1:0]    rd_data,
  input wire logic                          rd_valid,
  input wire logic                          rd_ready,
  input wire dsb_pkg::dsb_av_req_s          av_req,
  input wire logic                          avs_waitrequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_read_start: assert property ($rose(dq_oe) |-> !$past(cmd.load_n) && $past(cmd.read_write))
    else $error("read beat without read command");
  a_read_two: assert property ($rose(dq_oe) |=> dq_oe)
    else $error("read burst shorter than two beats");
  a_read_min: assert property ($fell(dq_oe) |-> $past(dq_oe, 2))
    else $error("bus released after one beat");
  a_nop_quiet: assert property (cmd.load_n && $past(cmd.load_n) |=> !dq_oe)
    else $error("bus driven without a read");
  a_write_quiet: assert property (!cmd.load_n && !cmd.read_write && !dq_oe |=> !dq_oe)
    else $error("bus driven after write command");
  a_echo_runs: assert property (ce && !rst |=> echo_clock != $past(echo_clock))
    else $error("echo clock missed a toggle");
  a_echo_frozen: assert property (!ce |=> $stable(echo_clock))
    else $error("echo clock moved while frozen");
  a_fifo_path: assert property ($rose(dq_oe) && !rd_valid |=> rd_valid && rd_data == $past(dq_o))
    else $error("first read word not in return stream");
  a_fifo_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("return word lost while stalled");
  a_wait_one: assert property ((av_req.read || av_req.write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  a_wait_idle: assert property (!(av_req.read || av_req.write) |-> !avs_waitrequest)
    else $error("wait asserted without request");
endmodule : dsb_sram_monitor

bind dsb_sram dsb_sram_monitor u_mon (.clk(clk), .rst(rst), .ce(ce), .cmd(cmd), .dq_o(dq_o), .dq_oe(dq_oe),
  .echo_clock(echo_clock), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .av_req(av_req),
  .avs_waitrequest(avs_waitrequest));

// *** tb/dsb_ctl_model.sv ***
`timescale 1ns/1ps
module dsb_ctl_model (
  input  wire logic                       clk,
  output dsb_pkg::dsb_cmd_s               cmd,
  output dsb_pkg::dsb_lanes_s             lanes,
  output logic [dsb_pkg::DATA_W-1:0]      dq_i
);
  initial begin
    cmd   = 22'h200000;
    lanes = 5'h1f;
    dq_i  = '0;
  end
  task automatic burst(input logic rw, input logic [19:0] a, input logic [35:0] d0, d1,
                       input logic [4:0] s0, s1);
    @(posedge clk);
    cmd <= {1'b0, rw, a};
    @(posedge clk);
    cmd.load_n <= 1'b1;
    if (!rw) begin
      dq_i  <= d0;
      lanes <= s0;
    end
    @(posedge clk);
    if (!rw) begin
      dq_i  <= d1;
      lanes <= s1;
    end
    @(posedge clk);
    // Stale data is inverted so a late sample cannot look right
    dq_i  <= ~dq_i;
    lanes <= 5'h1f;
  endtask : burst
  task automatic nop(input int n);
    @(posedge clk);
    cmd.read_write <= 1'b1;
    repeat (n) @(posedge clk);
  endtask : nop
endmodule : dsb_ctl_model

// *** tb/dsb_sram_tb.sv ***
`timescale 1ns/1ps
module dsb_sram_tb;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 ce = 1'b1;
  logic                 rd_ready = 1'b0;
  dsb_pkg::dsb_av_req_s av_req = '0;
  dsb_pkg::dsb_cmd_s    cmd;
  dsb_pkg::dsb_lanes_s  lanes;
  logic [35:0]          dq_i;
  logic [35:0]          dq_o;
  logic [35:0]          rd_data;
  logic [31:0]          avs_readdata;
  logic [31:0]          rdata;
  logic                 dq_oe;
  logic                 echo_clock;
  logic                 cmd_ready;
  logic                 rd_valid;
  logic                 avs_waitrequest;
  int                   fails = 0;
  int                   tests_run = 0;
  // Row: org, beat0 selects, beat1 selects, word at first address, word at flipped address
  localparam logic [83:0] tbl [8] = '{
    {2'd0, 5'h1d, 5'h1f, 36'h0000001ff, 36'h0}, {2'd0, 5'h1b, 5'h1f, 36'h00003fe00, 36'h0},
    {2'd0, 5'h17, 5'h1f, 36'h007fc0000, 36'h0}, {2'd0, 5'h01, 5'h0f, 36'hfffffffff, 36'hff8000000},
    {2'd1, 5'h05, 5'h1f, 36'h0000001ff, 36'h0}, {2'd1, 5'h03, 5'h01, 36'h00003fe00, 36'h00003ffff},
    {2'd2, 5'h1e, 5'h1f, 36'h0000001ff, 36'h0}, {2'd2, 5'h01, 5'h1e, 36'h0, 36'h0000001ff}};

  always #4 clk = ~clk;

  dsb_sram uut (.clk(clk), .rst(rst), .ce(ce), .cmd(cmd), .lanes(lanes), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe(dq_oe), .echo_clock(echo_clock), .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .av_req(av_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  dsb_ctl_model ctl (.clk(clk), .cmd(cmd), .lanes(lanes), .dq_i(dq_i));

  task automatic test_done;
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic chk(input logic [35:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // One wait state is expected, but the count is never assumed
  task automatic av(input logic we, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    av_req <= {~we, we, a, wd};
    // Waitrequest and read data are judged at the rising edge, before that edge's updates land
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest && n < 20);
    if (avs_waitrequest) begin
      chk(1, 0, "bus timeout");
      test_done();
    end else begin
      rdata = avs_readdata;
      av_req <= '0;
    end
  endtask : av
  task automatic pop(input logic [35:0] e);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!rd_valid && n < 40);
    if (!rd_valid) begin
      chk(1, 0, "return timeout");
      test_done();
    end else begin
      chk(rd_data, e, "return word");
      @(posedge clk);
      rd_ready <= 1'b1;
      @(posedge clk);
      rd_ready <= 1'b0;
    end
  endtask : pop
  task automatic t_regs;
    av(0, 4'h0, 0);
    chk({4'h0, rdata}, 36'h4, "ctrl reset");
    av(0, 4'h4, 0);
    chk({4'h0, rdata}, 36'h200, "status reset");
    av(0, 4'h8, 0);
    chk({4'h0, rdata}, 36'h0, "burst count reset");
    av(0, 4'hc, 0);
    chk({4'h0, rdata}, 36'h0, "unmapped read");
    $display("regs done");
  endtask : t_regs
  task automatic t_nop;
    logic e;
    ctl.nop(4);
    @(negedge clk);
    chk({35'h0, dq_oe}, 36'h0, "nop drives bus");
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    e = echo_clock;
    repeat (3) @(negedge clk);
    chk({35'h0, echo_clock}, {35'h0, e}, "echo while frozen");
    @(posedge clk);
    ce <= 1'b1;
    // A disabled block treats a read as no operation; the queue must stay empty
    av(1, 4'h0, 32'h0);
    ctl.burst(1, 20'h00000, '0, '0, 5'h1f, 5'h1f);
    @(negedge clk);
    chk(36'(rd_valid), 36'h0, "read while disabled");
    $display("nop done");
  endtask : t_nop
  task automatic t_lanes;
    logic [19:0] a;
    for (int i = 0; i < 8; i++) begin
      a = {19'h10, i[0]};
      av(1, 4'h0, 32'h4);
      ctl.burst(0, a, '0, '0, 5'h01, 5'h01);
      av(1, 4'h0, {29'h0, 1'b1, tbl[i][83:82]});
      ctl.burst(0, a, '1, '1, tbl[i][81:77], tbl[i][76:72]);
      ctl.burst(1, a, '0, '0, 5'h1f, 5'h1f);
      pop(tbl[i][71:36]);
      pop(tbl[i][35:0]);
    end
    $display("lanes done");
  endtask : t_lanes
  task automatic t_fifo;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      chk(36'(cmd_ready), 36'(i < 15), "read space");
      ctl.burst(1, 20'h21, '0, '0, 5'h1f, 5'h1f);
    end
    for (int j = 0; j < 30; j++) pop(j[0] ? 36'h1ff : 36'h0);
    repeat (2) @(negedge clk);
    chk(36'(rd_valid), 36'h0, "fifo empty");
    av(0, 4'h8, 0);
    chk({4'h0, rdata}, 36'd39, "burst count");
    $display("fifo done");
  endtask : t_fifo

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_nop();
    t_lanes();
    t_fifo();
    test_done();
  end
endmodule : dsb_sram_tb
